/* File: rtl/sf_front_pkg.sv */
// Purpose: Constants and types shared by the serial flash command front end.
// Assumes: One opcode byte, then 24 address bits, then don't-care bytes, MSB first.
// Notes:
// Notes on behaviour
// - Reset pin low aborts the running operation and returns the machine to idle.
// - Reset is held while the pin stays low; work resumes once it is high.
// - An internal power-on reset exists, so the reset pin is free at power-up.
// - Ready/busy is open drain: pulled low while self-timed work runs, else released.
// - Busy covers every program, compare and page-to-buffer transfer.
// - After power-up or reset: SPI mode 3, serial output high impedance.
// - After reset a chip select falling edge must come before any command.
// - Each chip select fall samples the idle clock level to pick the polarity.
// - Polarity set: 68 array read, 52 page read, 57 status read without address.
// - SPI set: E8 array read, D2 page read, D7 status read.
// - Buffer read 54/D4: 15 don't-care bits, 9 offset bits, one dummy byte.
// - Page commands carry 24 bits: 6 reserved, 9 page bits, 9 offset/don't-care bits.
// - Array and page reads need four dummy bytes before data appears.
// - 53 transfer, 60 compare, 58 rewrite take a page address and don't-care bits.
// - 83 program with erase, 88 program without erase take a page address.
// - 82 program through buffer with offset; 84 buffer write with offset; no dummies.
// - 81 page erase uses the full page; 50 block erase only six upper bits.
// - Program, erase, transfer, compare and rewrite opcodes work in all four modes.
// - Inputs sampled on rising clock edge, outputs shifted on falling edge.
// - Chip select fall begins a command; its rise ends it and starts self-timed work.
// - A finished compare writes its result to status bit 6.
package sf_front_pkg;

    // Opcodes, clock-polarity set
    localparam logic [7:0] OP_ARRAY_RD_POL = 8'h68;
    localparam logic [7:0] OP_PAGE_RD_POL  = 8'h52;
    localparam logic [7:0] OP_BUF_RD_POL   = 8'h54;
    localparam logic [7:0] OP_STATUS_POL   = 8'h57;
    // Opcodes, SPI mode set
    localparam logic [7:0] OP_ARRAY_RD_SPI = 8'he8;
    localparam logic [7:0] OP_PAGE_RD_SPI  = 8'hd2;
    localparam logic [7:0] OP_BUF_RD_SPI   = 8'hd4;
    localparam logic [7:0] OP_STATUS_SPI   = 8'hd7;
    // Opcodes valid in any mode
    localparam logic [7:0] OP_BUF_WRITE    = 8'h84;
    localparam logic [7:0] OP_PROG_ERASE   = 8'h83;
    localparam logic [7:0] OP_PROG_NOERASE = 8'h88;
    localparam logic [7:0] OP_PAGE_ERASE   = 8'h81;
    localparam logic [7:0] OP_BLOCK_ERASE  = 8'h50;
    localparam logic [7:0] OP_PROG_THRU    = 8'h82;
    localparam logic [7:0] OP_PAGE_TO_BUF  = 8'h53;
    localparam logic [7:0] OP_COMPARE      = 8'h60;
    localparam logic [7:0] OP_REWRITE      = 8'h58;

    // Bit counts within a frame
    localparam logic [6:0] CNT_FIRST       = 7'h01;
    localparam logic [6:0] CNT_OPCODE_END  = 7'h08;
    localparam logic [6:0] CNT_ADDR_END    = 7'h20;
    localparam logic [6:0] CNT_BUF_START   = 7'h28;
    localparam logic [6:0] CNT_ARRAY_START = 7'h40;

    // Address field positions
    localparam int OFFSET_MSB = 8;
    localparam int PAGE_LSB   = 9;
    localparam int PAGE_MSB   = 17;
    localparam int BLOCK_LSB  = 12;

    // Status byte layout
    localparam int STAT_READY_BIT   = 7;
    localparam int STAT_COMPARE_BIT = 6;
    localparam logic [5:0] STAT_LOW_BITS = 6'h00;

    // Values after reset, and the fill byte that array reads return
    localparam logic       CPOL_RESET    = 1'b1;
    localparam logic       COMPARE_RESET = 1'b0;
    localparam logic [7:0] ARRAY_FILL    = 8'hff;

    typedef enum logic [0:0] {ST_IDLE, ST_BUSY} core_state_type;

endpackage : sf_front_pkg

/* File: rtl/sf_sync2.sv */
// Purpose: Two flip-flop synchroniser for a group of levels.
// Assumes: Each bit is an independent quasi-static level.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module sf_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    // Levels
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_reg <= '0;
            q_o      <= '0;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule : sf_sync2
`default_nettype wire

/* File: rtl/sf_page_buffer.sv */
// Purpose: Page-sized SRAM buffer on the serial clock.
// Assumes: One write port clocked by the serial clock, asynchronous read.
// Notes: Out-of-range addresses read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module sf_page_buffer #(
    parameter int DEPTH = 264,
    parameter int AW    = 9
) (
    // Clock
    input  wire logic          clk_i,
    // Write port
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [7:0]    wdata_i,
    // Read port
    input  wire logic [AW-1:0] raddr_i,
    output logic      [7:0]    rdata_o
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk_i) begin
        if (we_i && (int'(waddr_i) < DEPTH)) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_comb begin
        rdata_o = 8'h00;
        if (int'(raddr_i) < DEPTH) begin
            rdata_o = mem[raddr_i];
        end
    end
endmodule : sf_page_buffer
`default_nettype wire

/* File: rtl/sf_command_front_end.sv */
// Purpose: Command front end: serial link decode, buffer access, busy and mode control.
// Assumes: Array engine outside runs the self-timed work and pulses op_done_i.
// Notes: Command fields cross to the core clock while the serial clock is quiet.
`timescale 1ns/1ps
`default_nettype none
module sf_command_front_end #(
    parameter int BUF_DEPTH = 264,
    parameter int OFFSET_W  = 9,
    parameter int PAGE_W    = 9
) (
    // Core clock and power-on reset
    input  wire logic                core_clk_i,
    input  wire logic                reset_i,
    // Reset pin, active low
    input  wire logic                reset_pin_n_i,
    // Serial link
    input  wire logic                sck_i,
    input  wire logic                cs_n_i,
    input  wire logic                si_i,
    output logic                     so_o,
    output logic                     so_oe_o,
    // Ready/busy open drain
    output logic                     rdy_busy_o,
    output logic                     rdy_busy_oe_o,
    // Mode and status
    output logic                     mode_cpol_o,
    output logic                     compare_result_o,
    // Array engine
    output logic                     op_start_o,
    output logic                     op_abort_o,
    output logic [7:0]               op_code_o,
    output logic [PAGE_W-1:0]        op_page_o,
    output logic [OFFSET_W-1:0]      op_offset_o,
    input  wire logic                op_done_i,
    input  wire logic                compare_equal_i
);
    import sf_front_pkg::*;

    typedef struct packed {
        logic [6:0]          cnt;
        logic [23:0]         sr;
        logic [OFFSET_W-1:0] ptr;
        logic [7:0]          tx;
        logic                out_en;
    } frame_type;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [23:0] addr;
        logic        op_ok;
        logic        addr_ok;
    } cmd_type;

    typedef struct packed {
        logic so;
        logic oe;
    } drive_type;

    typedef struct packed {
        core_state_type      state;
        logic                cs_d;
        logic                armed;
        logic                cpol;
        logic                busy;
        logic                rdy_level;
        logic                cmp;
        logic                start;
        logic                abort;
        logic [7:0]          code;
        logic [PAGE_W-1:0]   page;
        logic [OFFSET_W-1:0] offset;
    } core_type;

    frame_type fr_reg, fr_next;
    cmd_type   cmd_reg, cmd_next;
    drive_type drv_reg, drv_next;
    core_type  core_reg, core_next;

    logic                frame_clr;
    logic                buf_we;
    logic [7:0]          buf_rdata;
    logic [1:0]          stat_link;
    logic [2:0]          core_sync;
    logic                cs_s;
    logic                sck_s;
    logic                rst_pin_s;
    logic [7:0]          status_byte;
    logic                is_status;
    logic                is_buf_rd;
    logic                is_array_rd;
    logic                is_buf_wr;
    logic                self_timed;
    logic [OFFSET_W-1:0] ptr_inc;
    logic [7:0]          op_now;
    logic                op_seen;

    // Link side: frame state is cleared whenever chip select is high
    assign frame_clr = reset_i | cs_n_i;

    sf_sync2 #(.WIDTH(2)) u_link_sync (
        .clk_i   (sck_i),
        .reset_i (reset_i),
        .d_i     ({core_reg.busy, core_reg.cmp}),
        .q_o     (stat_link)
    );

    sf_page_buffer #(.DEPTH(BUF_DEPTH), .AW(OFFSET_W)) u_buffer (
        .clk_i   (sck_i),
        .we_i    (buf_we),
        .waddr_i (fr_reg.ptr),
        .wdata_i (fr_next.sr[7:0]),
        .raddr_i (fr_reg.ptr),
        .rdata_o (buf_rdata)
    );

    assign status_byte = {~stat_link[1], stat_link[0], STAT_LOW_BITS};

    // Opcode seen in the edge that completes it, so status output can start right after bit 8
    assign op_now = (fr_reg.cnt == (CNT_OPCODE_END - 7'h01)) ? {fr_reg.sr[6:0], si_i} : cmd_reg.opcode;
    assign op_seen = cmd_reg.op_ok || (fr_reg.cnt == (CNT_OPCODE_END - 7'h01));

    always_comb begin
        is_status   = (op_now == OP_STATUS_POL) || (op_now == OP_STATUS_SPI);
        is_buf_rd   = (op_now == OP_BUF_RD_POL) || (op_now == OP_BUF_RD_SPI);
        is_array_rd = (op_now == OP_ARRAY_RD_POL) || (op_now == OP_PAGE_RD_POL)
                   || (op_now == OP_ARRAY_RD_SPI) || (op_now == OP_PAGE_RD_SPI);
        is_buf_wr   = (op_now == OP_BUF_WRITE) || (op_now == OP_PROG_THRU);
    end

    assign ptr_inc = (fr_reg.ptr == OFFSET_W'(BUF_DEPTH - 1)) ? '0 : fr_reg.ptr + OFFSET_W'(1);

    always_comb begin
        fr_next = fr_reg;
        cmd_next = cmd_reg;
        buf_we = 1'b0;
        // Counter saturates in its top bit so the byte phase keeps running
        fr_next.cnt = fr_reg.cnt + 7'h01;
        fr_next.cnt[6] = fr_reg.cnt[6] | fr_next.cnt[6];
        fr_next.sr = {fr_reg.sr[22:0], si_i};
        if (fr_next.cnt == CNT_FIRST) begin
            cmd_next.op_ok = 1'b0;
            cmd_next.addr_ok = 1'b0;
        end
        if (fr_next.cnt == CNT_OPCODE_END) begin
            cmd_next.opcode = fr_next.sr[7:0];
            cmd_next.op_ok = 1'b1;
        end
        if (fr_next.cnt == CNT_ADDR_END) begin
            cmd_next.addr = fr_next.sr;
            cmd_next.addr_ok = 1'b1;
            // Offsets past the buffer end restart at zero
            fr_next.ptr = (int'(fr_next.sr[OFFSET_MSB:0]) < BUF_DEPTH) ? fr_next.sr[OFFSET_MSB:0] : '0;
        end
        if (fr_next.cnt[2:0] == 3'h0 && op_seen) begin
            if (is_status) begin
                fr_next.tx = status_byte;
                fr_next.out_en = 1'b1;
            end else if (is_buf_rd && fr_next.cnt >= CNT_BUF_START) begin
                fr_next.tx = buf_rdata;
                fr_next.ptr = ptr_inc;
                fr_next.out_en = 1'b1;
            end else if (is_array_rd && fr_next.cnt >= CNT_ARRAY_START) begin
                fr_next.tx = ARRAY_FILL;
                fr_next.out_en = 1'b1;
            end else if (is_buf_wr && fr_next.cnt >= CNT_BUF_START) begin
                buf_we = 1'b1;
                fr_next.ptr = ptr_inc;
            end
        end
    end

    always_ff @(posedge sck_i or posedge frame_clr) begin
        if (frame_clr) begin
            fr_reg <= '0;
        end else begin
            fr_reg <= fr_next;
        end
    end

    always_ff @(posedge sck_i or posedge reset_i) begin
        if (reset_i) begin
            cmd_reg <= '0;
        end else begin
            cmd_reg <= cmd_next;
        end
    end

    // Output shifts on the falling edge; unknown opcodes never raise out_en
    always_comb begin
        drv_next.oe = fr_reg.out_en;
        drv_next.so = fr_reg.tx[3'h7 - fr_reg.cnt[2:0]];
    end

    always_ff @(negedge sck_i or posedge frame_clr) begin
        if (frame_clr) begin
            drv_reg <= '0;
        end else begin
            drv_reg <= drv_next;
        end
    end

    // Core side
    sf_sync2 #(.WIDTH(3)) u_core_sync (
        .clk_i   (core_clk_i),
        .reset_i (reset_i),
        .d_i     ({~cs_n_i, sck_i, ~reset_pin_n_i}),
        .q_o     (core_sync)
    );

    // Inverted through the synchroniser so its reset value is the idle level: no false edge after reset
    assign cs_s = ~core_sync[2];
    assign sck_s = core_sync[1];
    assign rst_pin_s = ~core_sync[0];

    always_comb begin
        self_timed = 1'b0;
        case (cmd_reg.opcode)
            OP_PAGE_TO_BUF, OP_COMPARE, OP_REWRITE: self_timed = 1'b1;
            OP_PROG_ERASE, OP_PROG_NOERASE: self_timed = 1'b1;
            OP_PROG_THRU, OP_PAGE_ERASE, OP_BLOCK_ERASE: self_timed = 1'b1;
            default: self_timed = 1'b0;
        endcase
    end

    always_comb begin
        core_next = core_reg;
        core_next.cs_d = cs_s;
        core_next.start = 1'b0;
        core_next.rdy_level = 1'b0;
        // Command fields are read only after the frame ends, when the serial clock is still
        if (!rst_pin_s) begin
            core_next.state = ST_IDLE;
            core_next.armed = 1'b0;
            core_next.cpol = CPOL_RESET;
            core_next.abort = 1'b1;
        end else begin
            core_next.abort = 1'b0;
            if (core_reg.cs_d && !cs_s) begin
                core_next.cpol = sck_s;
                core_next.armed = 1'b1;
            end
            case (core_reg.state)
                ST_IDLE: begin
                    if (!core_reg.cs_d && cs_s && core_reg.armed && cmd_reg.op_ok
                        && cmd_reg.addr_ok && self_timed) begin
                        core_next.state = ST_BUSY;
                        core_next.start = 1'b1;
                        core_next.code = cmd_reg.opcode;
                        core_next.page = cmd_reg.addr[PAGE_MSB:PAGE_LSB];
                        core_next.offset = cmd_reg.addr[OFFSET_MSB:0];
                        if (cmd_reg.opcode == OP_BLOCK_ERASE) begin
                            core_next.page = {cmd_reg.addr[PAGE_MSB:BLOCK_LSB], 3'h0};
                        end
                    end
                end
                ST_BUSY: begin
                    if (op_done_i) begin
                        core_next.state = ST_IDLE;
                        if (core_reg.code == OP_COMPARE) begin
                            core_next.cmp = compare_equal_i;
                        end
                    end
                end
                default: core_next.state = ST_IDLE;
            endcase
        end
        core_next.busy = (core_next.state == ST_BUSY);
    end

    // Power-on reset comes from reset_i; the pin only aborts through the synchroniser
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            core_reg <= '{state: ST_IDLE, cs_d: 1'b1, armed: 1'b0, cpol: CPOL_RESET, busy: 1'b0,
                          rdy_level: 1'b0, cmp: COMPARE_RESET, start: 1'b0, abort: 1'b0,
                          code: 8'h00, page: '0, offset: '0};
        end else begin
            core_reg <= core_next;
        end
    end

    assign so_o = drv_reg.so;
    assign so_oe_o = drv_reg.oe;
    assign rdy_busy_o = core_reg.rdy_level;
    assign rdy_busy_oe_o = core_reg.busy;
    assign mode_cpol_o = core_reg.cpol;
    assign compare_result_o = core_reg.cmp;
    assign op_start_o = core_reg.start;
    assign op_abort_o = core_reg.abort;
    assign op_code_o = core_reg.code;
    assign op_page_o = core_reg.page;
    assign op_offset_o = core_reg.offset;

endmodule : sf_command_front_end
`default_nettype wire

/* File: verification/sf_command_front_end_sva.sv */
// Purpose: Concurrent checks on the command front end ports.
// Assumes: Pin reset passes a two-flop synchroniser on the core clock.
// Notes: Host keeps chip select high for many core cycles between frames.
`timescale 1ns/1ps
`default_nettype none
module sf_front_sva import sf_front_pkg::*; #(
    parameter int PAGE_W = 9
) (
    // Clock and reset
    input wire logic              core_clk_i,
    input wire logic              reset_i,
    // Pins
    input wire logic              reset_pin_n_i,
    input wire logic              cs_n_i,
    input wire logic              so_oe_o,
    input wire logic              rdy_busy_o,
    input wire logic              rdy_busy_oe_o,
    // Mode, status and engine
    input wire logic              mode_cpol_o,
    input wire logic              compare_result_o,
    input wire logic              op_start_o,
    input wire logic              op_abort_o,
    input wire logic [7:0]        op_code_o,
    input wire logic [PAGE_W-1:0] op_page_o,
    input wire logic              op_done_i
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    sequence pin_low3;
        !reset_pin_n_i [*3];
    endsequence
    sequence pin_high3;
        reset_pin_n_i [*3];
    endsequence
    chk_drain_low: assert property (rdy_busy_o == 1'b0)
        else $error("ready/busy data not low");
    chk_start_busy: assert property (op_start_o |-> rdy_busy_oe_o)
        else $error("start without busy");
    // Pin history guards against the synchroniser lag dropping busy
    chk_busy_holds: assert property (rdy_busy_oe_o && !op_done_i && reset_pin_n_i && $past(reset_pin_n_i)
        && $past(reset_pin_n_i, 2) |=> rdy_busy_oe_o)
        else $error("busy dropped early");
    chk_done_idle: assert property (rdy_busy_oe_o && op_done_i |=> !rdy_busy_oe_o)
        else $error("busy kept after done");
    chk_abort_idle: assert property (op_abort_o |-> !rdy_busy_oe_o && !op_start_o && mode_cpol_o)
        else $error("pin reset not idle");
    chk_abort_on: assert property (pin_low3 |=> op_abort_o)
        else $error("pin reset not held");
    chk_abort_off: assert property (pin_high3 |=> !op_abort_o)
        else $error("pin reset not left");
    chk_cs_quiet: assert property (cs_n_i |-> !so_oe_o)
        else $error("output driven while deselected");
    chk_one_pulse: assert property (op_start_o |=> !op_start_o)
        else $error("start longer than one cycle");
    chk_start_cs_high: assert property (op_start_o |-> cs_n_i && $past(cs_n_i))
        else $error("start before chip select rise");
    chk_cmp_kept: assert property (!(rdy_busy_oe_o && op_done_i) |=> $stable(compare_result_o))
        else $error("compare changed without done");
    chk_block_page: assert property (op_start_o && op_code_o == OP_BLOCK_ERASE |-> op_page_o[2:0] == 3'h0)
        else $error("block erase low page bits set");
endmodule : sf_front_sva
bind sf_command_front_end sf_front_sva #(.PAGE_W(PAGE_W)) sf_front_sva_inst (.*);
`default_nettype wire

/* File: verification/sf_host_model.sv */
// Purpose: Host controller model driving the serial link.
// Assumes: Link clock half period 24 ns; idle level chosen per frame.
// Notes: Clock stands still between frames; data line flips when released.
`timescale 1ns/1ps
`default_nettype none
module sf_host_model (
    // Link
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      si_o,
    input  wire logic so_i,
    input  wire logic so_oe_i
);
    initial begin
        sck_o = 1'b1;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end
    // Bit k of the frame travels at tx[128-k]; rx holds z where the output was off
    task automatic frame(input logic pol, input logic [127:0] tx, input int n, output logic [127:0] rx);
        rx = 'z;
        sck_o = pol;
        #13;
        cs_n_o = 1'b0;
        #30;
        for (int i = 127; i > 127 - n; i--) begin
            sck_o = 1'b0;
            si_o = tx[i];
            #24;
            sck_o = 1'b1;
            rx[i] = so_oe_i ? so_i : 1'bz;
            #24;
        end
        sck_o = pol;
        si_o = ~si_o;
        #30;
        cs_n_o = 1'b1;
        #300;
    endtask : frame
endmodule : sf_host_model
`default_nettype wire

/* File: verification/serial_flash_command_front_end_tb.sv */
// Purpose: Self-checking bench for the serial flash command front end.
// Assumes: Engine answers after a set delay; host model drives the link.
// Notes: Busy lasts long enough for a status read to see it.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_command_front_end_tb;
    import sf_front_pkg::*;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic reset_pin_n_i = 1'b1;
    logic op_done_i = 1'b0;
    logic compare_equal_i = 1'b0;
    wire sck, cs_n, si, so, so_oe, rb, rb_oe, cpol, cmp, start, abort;
    wire [7:0] code;
    wire [8:0] page, offs;
    wire rdy_pin = rb_oe ? rb : 1'b1;
    logic [127:0] rx;
    logic [7:0] ops [10] = '{8'h53, 8'h60, 8'h58, 8'h83, 8'h88, 8'h82, 8'h81, 8'h50, 8'h60, 8'h58};
    int fail_count = 0;
    int checked = 0;
    int starts = 0;
    int timer = 0;
    int delay = 500;
    logic eq = 1'b0;
    sf_command_front_end sf_command_front_end_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .reset_pin_n_i(reset_pin_n_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe),
        .rdy_busy_o(rb), .rdy_busy_oe_o(rb_oe), .mode_cpol_o(cpol), .compare_result_o(cmp),
        .op_start_o(start), .op_abort_o(abort), .op_code_o(code), .op_page_o(page), .op_offset_o(offs),
        .op_done_i(op_done_i), .compare_equal_i(compare_equal_i));
    sf_host_model sf_host_model_inst (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_oe_i(so_oe));
    always #2.5 core_clk_i = ~core_clk_i;
    // Array engine stand-in: one done pulse a set delay after each start
    always @(negedge core_clk_i) begin
        op_done_i <= (timer == 1);
        compare_equal_i <= eq;
        if (start) begin
            starts <= starts + 1;
            timer <= delay;
        end else if (timer != 0) begin
            timer <= timer - 1;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic cmd(input logic pol, input logic [127:0] tx, input int n);
        sf_host_model_inst.frame(pol, tx, n, rx);
    endtask : cmd
    task automatic stat(input logic pol, input logic [7:0] exp);
        cmd(pol, {pol ? OP_STATUS_SPI : OP_STATUS_POL, 120'h0}, 24);
        chk(rx[119:104], {exp, exp});
    endtask : stat
    task automatic wait_idle();
        for (int i = 0; i < 3000 && rb_oe !== 1'b0; i++) @(negedge core_clk_i);
    endtask : wait_idle
    task automatic t_ops();
        logic [7:0] op;
        logic [8:0] pg;
        logic c;
        int s0;
        c = 1'b0;
        for (int i = 0; i < 10; i++) begin
            op = ops[i];
            pg = 9'(i * 51 + 3);
            eq = i[0];
            s0 = starts;
            cmd(i[0], {op, 6'h0, pg, 9'(i * 29), 96'h0}, 32);
            chk(starts, s0 + 1);
            chk(code, op);
            chk(page, op == OP_BLOCK_ERASE ? {pg[8:3], 3'h0} : pg);
            if (op == OP_PROG_THRU) chk(offs, 9'(i * 29));
            chk(cpol, i[0]);
            chk(rdy_pin, 1'b0);
            stat(i[0], {1'b0, c, 6'h0});
            wait_idle();
            if (op == OP_COMPARE) c = eq;
            chk(cmp, c);
            stat(~i[0], {1'b1, c, 6'h0});
        end
    endtask : t_ops
    task automatic t_buf();
        int s0;
        s0 = starts;
        cmd(1'b1, {OP_BUF_WRITE, 15'h0, 9'd262, 24'ha53ce1, 72'h0}, 56);
        chk(starts, s0);
        cmd(1'b1, {OP_BUF_RD_SPI, 15'h0, 9'd262, 96'h0}, 64);
        chk(rx[95:88], 8'hzz);
        chk(rx[87:64], 24'ha53ce1);
        cmd(1'b0, {OP_BUF_RD_POL, 15'h0, 9'd263, 96'h0}, 56);
        chk(rx[87:72], 16'h3ce1);
    endtask : t_buf
    task automatic t_reads();
        logic [7:0] rd [4] = '{8'h68, 8'he8, 8'h52, 8'hd2};
        for (int i = 0; i < 4; i++) begin
            cmd(i[0], {rd[i], 6'h0, 9'(i), 9'h0, 96'h0}, 80);
            chk(rx[95:64], 32'hzzzzzzzz);
            chk(rx[63:48], 16'hffff);
        end
    endtask : t_reads
    task automatic t_unknown();
        int s0;
        s0 = starts;
        cmd(1'b0, {8'h3c, 120'h0}, 48);
        chk(rx[119:88], 32'hzzzzzzzz);
        chk(starts, s0);
    endtask : t_unknown
    // Late done from the aborted op must be ignored
    task automatic t_pin();
        delay = 2000;
        cmd(1'b0, {OP_PROG_ERASE, 6'h0, 9'h1ff, 9'h0, 96'h0}, 32);
        chk(cpol, 1'b0);
        @(negedge core_clk_i);
        reset_pin_n_i = 1'b0;
        repeat (20) @(negedge core_clk_i);
        chk({abort, rb_oe, cpol}, 3'b101);
        reset_pin_n_i = 1'b1;
        repeat (2500) @(negedge core_clk_i);
        chk({abort, rb_oe}, 2'b00);
        delay = 300;
        cmd(1'b1, {OP_PAGE_TO_BUF, 6'h0, 9'h00a, 9'h0, 96'h0}, 32);
        chk(rb_oe, 1'b1);
        wait_idle();
    endtask : t_pin
    task automatic end_of_test();
        if (fail_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    initial begin
        // Supply ramp is not modelled; the host idles through reset before its first frame
        repeat (6) @(negedge core_clk_i);
        reset_i = 1'b0;
        chk({so_oe, rb_oe, cpol, start}, 4'b0010);
        t_ops();
        t_buf();
        t_reads();
        t_unknown();
        t_pin();
        end_of_test();
    end
    initial begin
        #300000;
        fail_count++;
        end_of_test();
    end
endmodule : serial_flash_command_front_end_tb
`default_nettype wire
